/* uio_pkg.sv */
// Shared constants for the unified parallel I/O controller
package uio_pkg;

  // Geometry
  localparam int unsigned LINE_COUNT = 32;               // Implemented I/O lines
  localparam int unsigned ADDR_W     = 8;                // Register address width
  localparam int unsigned DATA_W     = 32;               // Register data width

  // Register byte offsets
  localparam logic [7:0] OFS_OUTPUT_ENABLE_SET       = 8'h10;
  localparam logic [7:0] OFS_OUTPUT_ENABLE_CLEAR     = 8'h14;
  localparam logic [7:0] OFS_DIRECTION_STATUS        = 8'h18;
  localparam logic [7:0] OFS_DRIVE_HIGH_SET          = 8'h30;
  localparam logic [7:0] OFS_DRIVE_LOW_SET           = 8'h34;
  localparam logic [7:0] OFS_PROGRAMMED_LEVEL_STATUS = 8'h38;
  localparam logic [7:0] OFS_PIN_LEVEL_STATUS        = 8'h3C;
  localparam logic [7:0] OFS_OPEN_DRAIN_SET          = 8'h40;
  localparam logic [7:0] OFS_OPEN_DRAIN_CLEAR        = 8'h44;
  localparam logic [7:0] OFS_OPEN_DRAIN_STATUS       = 8'h48;
  localparam logic [7:0] OFS_CLOCK_GATE_ON           = 8'h50;
  localparam logic [7:0] OFS_CLOCK_GATE_OFF          = 8'h54;
  localparam logic [7:0] OFS_CLOCK_GATE_STATUS       = 8'h58;
  localparam logic [7:0] OFS_CONTROLLER_COMMAND      = 8'h60;
  localparam logic [7:0] OFS_SPECIAL_FUNCTION_SELECT = 8'h64;
  localparam logic [7:0] OFS_LEVEL_CHANGE_STATUS     = 8'h70;
  localparam logic [7:0] OFS_IRQ_MASK_SET            = 8'h74;
  localparam logic [7:0] OFS_IRQ_MASK_CLEAR          = 8'h78;
  localparam logic [7:0] OFS_IRQ_MASK_STATUS         = 8'h7C;

  // Field positions
  localparam int unsigned CLOCK_OUT_SELECT_BIT = 31;     // Core clock onto line 31
  localparam int unsigned WAIT_IN_SELECT_BIT   = 30;     // Line 30 feeds bus wait
  localparam int unsigned CLOCK_OUT_LINE       = 31;     // Line shared with clock out
  localparam int unsigned WAIT_IN_LINE         = 30;     // Line shared with bus wait
  localparam int unsigned SOFT_RESET_BIT       = 0;      // Command register bit
  localparam int unsigned CLOCK_GATE_BIT       = 0;      // Clock gate bit

  // Writable bits of the mode register
  localparam logic [31:0] MODE_WRITE_MASK = 32'hC0000000;

  // Reset values
  localparam logic [31:0] RST_DIRECTION    = 32'h00000000;
  localparam logic [31:0] RST_LEVEL        = 32'h00000000;
  localparam logic [31:0] RST_OPEN_DRAIN   = 32'h00000000;
  localparam logic [31:0] RST_MODE         = 32'h00000000;
  localparam logic [31:0] RST_CHANGE       = 32'h00000000;
  localparam logic [31:0] RST_MASK         = 32'h00000000;
  localparam logic        RST_CLOCK_GATE   = 1'b0;
  localparam logic [31:0] READ_ZERO        = 32'h00000000;

  // Synchroniser settling cycles before change detection is armed
  localparam int unsigned SYNC_ARM_CYCLES = 2;

endpackage

/* uio_sample_if.sv */
`timescale 1ns/1ps
// Synchronised pin levels and change pulses from the sampler
interface uio_sample_if;
  logic [31:0] level;                                   // Synchronised pin levels
  logic [31:0] change;                                  // One-cycle change pulses

  modport producer (output level, output change);
  modport consumer (input level, input change);
endinterface

/* uio_pin_sampler.sv */
`timescale 1ns/1ps
// Two-stage synchroniser and edge detector for all lines
module uio_pin_sampler (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Raw pin levels
  input  wire logic [31:0] pin_in,
  // Sampled results
  uio_sample_if.producer   smp
);

  logic [31:0] meta_reg;                                // First stage, read only by second
  logic [31:0] sync_reg;                                // Second stage, safe level
  logic [31:0] prev_reg;                                // Level one cycle earlier
  logic [uio_pkg::SYNC_ARM_CYCLES-1:0] arm_reg;         // Settling shift chain
  logic        armed_reg;                               // Previous level flop also real

  // Synchroniser chain; never reset by soft reset so levels stay valid
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= 32'h00000000;
      sync_reg <= 32'h00000000;
      prev_reg <= 32'h00000000;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Arm only once chain and previous flop hold real levels; the previous
  // flop keeps its reset zero one edge longer, so a line idling high
  // would otherwise show a false edge right after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arm_reg   <= '0;
      armed_reg <= 1'b0;
    end else begin
      arm_reg   <= {arm_reg[uio_pkg::SYNC_ARM_CYCLES-2:0], 1'b1};
      armed_reg <= arm_reg[uio_pkg::SYNC_ARM_CYCLES-1];
    end
  end

  // One pulse per settled transition, either direction
  assign smp.level  = sync_reg;
  assign smp.change = (sync_reg ^ prev_reg) & {32{armed_reg}};

endmodule

/* uio_ctrl.sv */
// Notes on behaviour
// - Thirty-two dedicated lines, bit index equals line
// - Enable/disable writes set direction; status reads it
// - Set/clear writes program level; status reads it
// - Input lines are never driven, except line 31 with clock out selected
// - Pin level status returns actual pin levels
// - Mask set/clear by ones; zeros leave unchanged
// - Any pin edge sets its change bit while the clock gate is on
// - Interrupt when any unmasked change bit set
// - Reading change status returns then clears it
// - Unimplemented bits ignore writes, read zero
// - Open-drain lines drive low only, release high, except line 31 with clock out selected
// - Open-drain set/clear writes; status reports selection
// - Mode bit 31 selects clock out on line 31
// - Mode bit 30 selects bus wait on line 30
// - Selected lines carry clock or wait signal
// - Clock gate on/off writes; status bit 0
// - Soft reset clears all but clock gate
`timescale 1ns/1ps
module uio_ctrl (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // I/O lines
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  // Special functions
  input  wire logic        core_clock_src,
  output logic             bus_wait_input_n,
  // Interrupt toward the system controller
  output logic             uio_irq
);

  // Write hit decode, shared by every write-triggered register
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // Set/clear update; clear bits drop, set bits rise
  function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] set_bits,
                                          input logic [31:0] clr_bits);
    set_clr = (cur | set_bits) & ~clr_bits;
  endfunction

  // Held state
  logic [31:0] direction_reg;                          // One marks an output line
  logic [31:0] level_reg;                              // Programmed output levels
  logic [31:0] open_drain_reg;                         // One marks open-drain line
  logic [31:0] mode_reg;                               // Special function select
  logic [31:0] change_reg;                             // Sticky change flags
  logic [31:0] mask_reg;                               // Interrupt mask
  logic        clock_gate_reg;                         // Peripheral clock state
  logic        irq_reg;                                // Interrupt output flop
  logic [31:0] pin_out_reg;                            // Pin drive value flop
  logic [31:0] pin_oe_reg;                             // Pin drive enable flop
  logic        wait_reg;                               // Wait output flop
  logic [31:0] rdata_reg;                              // Read data flop

  // Next values
  logic [31:0] change_next;                            // Change flags after events
  logic [31:0] rdata_next;                             // Read mux result
  logic [31:0] pin_out_next;                           // Per-line drive value
  logic [31:0] pin_oe_next;                            // Per-line drive enable

  // Decoded strobes
  logic        soft_rst;                               // Soft reset command
  logic        cfg_ok;                                 // Config writes allowed
  logic        change_rd;                              // Change status read
  logic [31:0] wr_dir_set;                             // Direction enable bits
  logic [31:0] wr_dir_clr;                             // Direction disable bits
  logic [31:0] wr_lvl_set;                             // Drive high bits
  logic [31:0] wr_lvl_clr;                             // Drive low bits
  logic [31:0] wr_od_set;                              // Open-drain enable bits
  logic [31:0] wr_od_clr;                              // Open-drain disable bits
  logic [31:0] wr_msk_set;                             // Mask enable bits
  logic [31:0] wr_msk_clr;                             // Mask disable bits

  // Sampler link
  uio_sample_if smp ();

  // Pin synchroniser and edge detector
  uio_pin_sampler u_sampler (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (pin_in),
    .smp     (smp.producer)
  );

  // Soft reset acts on a one in its bit only; a zero is harmless
  assign soft_rst = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_CONTROLLER_COMMAND) &&
                    reg_wdata[uio_pkg::SOFT_RESET_BIT];

  // With the peripheral clock gated, configuration writes are lost
  assign cfg_ok = clock_gate_reg;

  // Status read that clears the change flags
  assign change_rd = reg_rd && (reg_addr == uio_pkg::OFS_LEVEL_CHANGE_STATUS);

  // Per-register write data, zero when not addressed
  assign wr_dir_set = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_OUTPUT_ENABLE_SET)   ? reg_wdata : 32'h00000000;
  assign wr_dir_clr = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_OUTPUT_ENABLE_CLEAR) ? reg_wdata : 32'h00000000;
  assign wr_lvl_set = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_DRIVE_HIGH_SET)      ? reg_wdata : 32'h00000000;
  assign wr_lvl_clr = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_DRIVE_LOW_SET)       ? reg_wdata : 32'h00000000;
  assign wr_od_set  = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_OPEN_DRAIN_SET)      ? reg_wdata : 32'h00000000;
  assign wr_od_clr  = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_OPEN_DRAIN_CLEAR)    ? reg_wdata : 32'h00000000;
  assign wr_msk_set = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_IRQ_MASK_SET)        ? reg_wdata : 32'h00000000;
  assign wr_msk_clr = wr_hit(reg_wr, reg_addr, uio_pkg::OFS_IRQ_MASK_CLEAR)      ? reg_wdata : 32'h00000000;

  // Direction: ones in enable make outputs, ones in disable make inputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      direction_reg <= uio_pkg::RST_DIRECTION;
    end else if (cfg_ok) begin
      direction_reg <= set_clr(direction_reg, wr_dir_set, wr_dir_clr);
    end
  end

  // Programmed level, kept even while the line is an input
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      level_reg <= uio_pkg::RST_LEVEL;
    end else if (cfg_ok) begin
      level_reg <= set_clr(level_reg, wr_lvl_set, wr_lvl_clr);
    end
  end

  // Open-drain selection per line
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      open_drain_reg <= uio_pkg::RST_OPEN_DRAIN;
    end else if (cfg_ok) begin
      open_drain_reg <= set_clr(open_drain_reg, wr_od_set, wr_od_clr);
    end
  end

  // Mode register; only the two select bits exist
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      mode_reg <= uio_pkg::RST_MODE;
    end else if (cfg_ok && wr_hit(reg_wr, reg_addr, uio_pkg::OFS_SPECIAL_FUNCTION_SELECT)) begin
      mode_reg <= reg_wdata & uio_pkg::MODE_WRITE_MASK;
    end
  end

  // Interrupt mask; zero bits in either write leave the mask alone
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      mask_reg <= uio_pkg::RST_MASK;
    end else if (cfg_ok) begin
      mask_reg <= set_clr(mask_reg, wr_msk_set, wr_msk_clr);
    end
  end

  // Clock gate survives soft reset and accepts writes while off
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clock_gate_reg <= uio_pkg::RST_CLOCK_GATE;
    end else if (wr_hit(reg_wr, reg_addr, uio_pkg::OFS_CLOCK_GATE_ON) &&
                 reg_wdata[uio_pkg::CLOCK_GATE_BIT]) begin
      clock_gate_reg <= 1'b1;
    end else if (wr_hit(reg_wr, reg_addr, uio_pkg::OFS_CLOCK_GATE_OFF) &&
                 reg_wdata[uio_pkg::CLOCK_GATE_BIT]) begin
      clock_gate_reg <= 1'b0;
    end
  end

  // Change flags: with the gate on, a new edge wins over a read or soft reset in the same cycle
  always_comb begin
    change_next = change_reg;
    if (change_rd || soft_rst) begin
      change_next = 32'h00000000;
    end
    if (cfg_ok) begin
      change_next = change_next | smp.change;
    end
  end

  // Sticky change register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      change_reg <= uio_pkg::RST_CHANGE;
    end else begin
      change_reg <= change_next;
    end
  end

  // Interrupt follows the flags one cycle later
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(change_reg & mask_reg);
    end
  end

  // Per-line drive; open drain never drives a one, except line 31 with clock out selected
  always_comb begin
    pin_out_next = 32'h00000000;
    pin_oe_next  = 32'h00000000;
    for (int i = 0; i < uio_pkg::LINE_COUNT; i++) begin
      if (!direction_reg[i]) begin
        pin_oe_next[i]  = 1'b0;
        pin_out_next[i] = 1'b0;
      end else if (open_drain_reg[i]) begin
        pin_oe_next[i]  = ~level_reg[i];
        pin_out_next[i] = 1'b0;
      end else begin
        pin_oe_next[i]  = 1'b1;
        pin_out_next[i] = level_reg[i];
      end
    end
    // Clock out takes line 31 over, whatever its direction
    if (mode_reg[uio_pkg::CLOCK_OUT_SELECT_BIT]) begin
      pin_oe_next[uio_pkg::CLOCK_OUT_LINE]  = 1'b1;
      pin_out_next[uio_pkg::CLOCK_OUT_LINE] = core_clock_src;
    end
    // Wait input needs line 30 released so the bus device can drive it
    if (mode_reg[uio_pkg::WAIT_IN_SELECT_BIT]) begin
      pin_oe_next[uio_pkg::WAIT_IN_LINE]  = 1'b0;
      pin_out_next[uio_pkg::WAIT_IN_LINE] = 1'b0;
    end
  end

  // Pin drive flops; one cycle behind the registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_out_reg <= 32'h00000000;
      pin_oe_reg  <= 32'h00000000;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  // Wait line toward the bus interface; idle high when not selected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else if (mode_reg[uio_pkg::WAIT_IN_SELECT_BIT]) begin
      wait_reg <= smp.level[uio_pkg::WAIT_IN_LINE];
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read mux; write-only and unmapped offsets read zero
  always_comb begin
    rdata_next = uio_pkg::READ_ZERO;
    unique case (reg_addr)
      uio_pkg::OFS_DIRECTION_STATUS: begin
        rdata_next = direction_reg;
      end
      uio_pkg::OFS_PROGRAMMED_LEVEL_STATUS: begin
        rdata_next = level_reg;
      end
      uio_pkg::OFS_PIN_LEVEL_STATUS: begin
        rdata_next = smp.level;
      end
      uio_pkg::OFS_OPEN_DRAIN_STATUS: begin
        rdata_next = open_drain_reg;
      end
      uio_pkg::OFS_CLOCK_GATE_STATUS: begin
        rdata_next = {31'h00000000, clock_gate_reg};
      end
      uio_pkg::OFS_SPECIAL_FUNCTION_SELECT: begin
        rdata_next = mode_reg;
      end
      uio_pkg::OFS_LEVEL_CHANGE_STATUS: begin
        rdata_next = change_reg;
      end
      uio_pkg::OFS_IRQ_MASK_STATUS: begin
        rdata_next = mask_reg;
      end
      default: begin
        rdata_next = uio_pkg::READ_ZERO;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_reg <= uio_pkg::READ_ZERO;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= uio_pkg::READ_ZERO;
    end
  end

  // Outputs straight from flops
  assign reg_rdata        = rdata_reg;
  assign pin_out          = pin_out_reg;
  assign pin_oe           = pin_oe_reg;
  assign bus_wait_input_n = wait_reg;
  assign uio_irq          = irq_reg;

endmodule

/* uio_ctrl_asserts.sv */
`timescale 1ns/1ps
// Port checks for the I/O controller
module uio_ctrl_asserts (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Lines and special functions
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic        core_clock_src,
  input wire logic        bus_wait_input_n,
  input wire logic        uio_irq
);
  logic       gate_reg;  // Shadow of the clock gate
  logic [1:0] mode_reg;  // Shadow of mode bits 31:30

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Gate outlives a soft reset; only hard reset or an off write clears it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gate_reg <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h50 && reg_wdata[0]) begin
      gate_reg <= 1'b1;
    end else if (reg_wr && reg_addr == 8'h54 && reg_wdata[0]) begin
      gate_reg <= 1'b0;
    end
  end

  // Mode writes land only while the gate is on
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (reg_wr && reg_addr == 8'h60 && reg_wdata[0])) begin
      mode_reg <= 2'h0;
    end else if (reg_wr && reg_addr == 8'h64 && gate_reg) begin
      mode_reg <= reg_wdata[31:30];
    end
  end

  chk_read_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (reg_rd && reg_addr inside {8'h00, 8'h1C, 8'h4C, 8'h10} |=> reg_rdata == 32'h0)
    else $error("unmapped or write-only read not zero");
  chk_gate_status: assert property (reg_rd && reg_addr == 8'h58 |=> reg_rdata == {31'h0, gate_reg})
    else $error("clock gate status wrong");
  chk_mode_bits: assert property (reg_rd && reg_addr == 8'h64 |=> reg_rdata == {mode_reg, 30'h0})
    else $error("mode readback wrong");
  chk_change_clear: assert property (($stable(pin_in)[*4] ##0 (reg_rd && reg_addr == 8'h70)) ##1
    (reg_rd && reg_addr == 8'h70 && $stable(pin_in)) |=> reg_rdata == 32'h0)
    else $error("change flags survived a read");
  chk_soft_reset: assert property (reg_wr && reg_addr == 8'h60 && reg_wdata[0] |-> ##3
    (pin_oe == 32'h0 && !uio_irq && bus_wait_input_n))
    else $error("soft reset left state behind");
  chk_wait_follow: assert property (!bus_wait_input_n |-> !$past(pin_in[30], 3))
    else $error("wait asserted without low line");
  chk_clock_drive: assert property (mode_reg[1] && $past(mode_reg[1]) && $past(mode_reg[1], 2) |->
    pin_oe[31] && pin_out[31] == $past(core_clock_src))
    else $error("core clock not on line 31");
  chk_wait_free: assert property (mode_reg[0] && $past(mode_reg[0]) && $past(mode_reg[0], 2) |-> !pin_oe[30])
    else $error("line 30 driven while feeding wait");
endmodule

/* uio_pin_model.sv */
`timescale 1ns/1ps
// Board side of the lines: optional drivers and a pull-up on each line
module uio_pin_model (
  // Device side
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  // Board drivers
  input  wire logic [31:0] ext_drive,
  input  wire logic [31:0] ext_level,
  // Resolved wire
  output logic      [31:0] pin_level,
  output logic             clash
);
  // Pull-up makes a released line high, never a stale value
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_drive[i]) begin
        pin_level[i] = ext_level[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end

  // Both sides driving opposite levels
  assign clash = |(pin_oe & ext_drive & (pin_out ^ ext_level));
endmodule

/* uio_ctrl_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the I/O controller
module uio_ctrl_test;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;                // Compare every bit
  logic        sys_clk        = 1'b0;                        // 20 MHz clock
  logic        rst_n          = 1'b0;                        // Sync reset
  logic [7:0]  reg_addr       = 8'h00;                       // Bus address
  logic [31:0] reg_wdata      = 32'h0;                       // Bus write data
  logic        reg_wr         = 1'b0;                        // Write strobe
  logic        reg_rd         = 1'b0;                        // Read strobe
  logic        rd_seen        = 1'b0;                        // Read result due
  logic        core_clock_src = 1'b0;                        // Core clock stand-in
  logic [31:0] ext_drive      = 32'h0;                       // Board drivers on
  logic [31:0] ext_level      = 32'h0;                       // Board driver levels
  logic [31:0] reg_rdata, pin_out, pin_oe, pin_level;        // Design results
  logic        bus_wait_input_n, uio_irq, clash;             // Flags
  logic [31:0] dir_e, lvl_e, od_e, msk_e, ext_e, chg_e, c;   // Expected state
  logic [31:0] exp_q[$], keep_q[$];                          // Read notes
  logic [7:0]  zero_a [11] = '{8'h18, 8'h38, 8'h48, 8'h58, 8'h64, 8'h70, 8'h7C, 8'h00, 8'h1C, 8'h4C, 8'h10};
  int          errors = 0, compares = 0, cycles = 0;         // Counters

  // Clocks; core clock runs at half rate
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) core_clock_src <= ~core_clock_src;

  uio_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_level), .pin_out(pin_out),
    .pin_oe(pin_oe), .core_clock_src(core_clock_src), .bus_wait_input_n(bus_wait_input_n), .uio_irq(uio_irq));
  uio_pin_model pin_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive), .ext_level(ext_level),
    .pin_level(pin_level), .clash(clash));

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read data compared under the note's keep mask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] keep);
    cmp_word(got & keep, exp & keep);
  endtask

  task automatic final_report;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus tasks leave their strobe up so calls may run back to back;
  // after a tick they first wait for the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (!sys_clk) @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    if (!sys_clk) @(posedge sys_clk);
    exp_q.push_back(e);
    keep_q.push_back(k);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic tick(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);                                            // Outputs settled here
  endtask

  // Result watcher: data stands one cycle after the strobe
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) if (rd_seen) cmp_rd(reg_rdata, exp_q.pop_front(), keep_q.pop_front());

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    void'($urandom(38823));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (zero_a[i]) rd(zero_a[i], 32'h0, ALL);
    tick(1);
    cmp_word(pin_oe, 32'h0);
    cmp_word({30'h0, uio_irq, bus_wait_input_n}, 32'h1);
    $display("reset test done");
    // Gate off refuses setup, then gate on
    wr(8'h10, ALL);
    wr(8'h64, ALL);
    rd(8'h18, 32'h0, ALL);
    wr(8'h50, 32'h1);
    rd(8'h58, 32'h1, ALL);
    $display("gate test done");
    // Direction, levels and pin readback
    dir_e = $urandom;
    lvl_e = $urandom;
    c = $urandom;
    ext_e = $urandom;
    wr(8'h10, dir_e);
    wr(8'h14, c);
    wr(8'h30, lvl_e);
    wr(8'h34, c);
    dir_e = dir_e & ~c;
    lvl_e = lvl_e & ~c;
    rd(8'h18, dir_e, ALL);
    rd(8'h38, lvl_e, ALL);
    ext_drive <= ~dir_e;
    ext_level <= ext_e;
    tick(5);
    cmp_word(pin_oe, dir_e);
    cmp_word(pin_out & dir_e, lvl_e & dir_e);
    cmp_word({31'h0, clash}, 32'h0);
    rd(8'h3C, (dir_e & lvl_e) | (~dir_e & ext_e), ALL);
    // Open drain selection
    od_e = $urandom;
    wr(8'h40, od_e);
    wr(8'h44, c);
    od_e = od_e & ~c;
    rd(8'h48, od_e, ALL);
    tick(3);
    cmp_word(pin_oe, dir_e & ~(od_e & lvl_e));
    cmp_word(pin_out & od_e & dir_e, 32'h0);
    $display("drive test done");
    // Change flags and interrupt
    rd(8'h70, 32'h0, 32'h0);
    msk_e = $urandom;
    wr(8'h74, msk_e);
    wr(8'h78, c);
    msk_e = msk_e & ~c;
    rd(8'h7C, msk_e, ALL);
    chg_e = $urandom & ~dir_e;
    ext_e = ext_e ^ chg_e;
    ext_level <= ext_e;
    wr(8'h34, lvl_e);
    chg_e = chg_e | (dir_e & lvl_e);
    tick(8);
    cmp_word({31'h0, uio_irq}, {31'h0, |(chg_e & msk_e)});
    rd(8'h70, chg_e, ALL);
    rd(8'h70, 32'h0, ALL);
    tick(3);
    cmp_word({31'h0, uio_irq}, 32'h0);
    wr(8'h78, ALL);
    chg_e = $urandom & ~dir_e;
    ext_e = ext_e ^ chg_e;
    ext_level <= ext_e;
    tick(8);
    cmp_word({31'h0, uio_irq}, 32'h0);
    rd(8'h70, chg_e, ALL);
    $display("change test done");
    // Special functions on lines 31 and 30
    wr(8'h64, ALL);
    rd(8'h64, 32'hC0000000, ALL);
    ext_drive <= ~dir_e | 32'h40000000;
    for (int v = 0; v < 2; v++) begin
      ext_e[30] = v[0];
      if (!sys_clk) @(posedge sys_clk);
      ext_level <= ext_e;
      tick(6);
      cmp_word({31'h0, bus_wait_input_n}, {31'h0, ext_e[30]});
    end
    cmp_word(pin_oe & 32'hC0000000, 32'h80000000);
    $display("special test done");
    // Soft reset keeps only the gate
    wr(8'h60, 32'h0);
    rd(8'h64, 32'hC0000000, ALL);
    wr(8'h60, 32'h1);
    tick(4);
    foreach (zero_a[i]) if (zero_a[i] != 8'h70) rd(zero_a[i], {31'h0, zero_a[i] == 8'h58}, ALL);
    tick(1);
    cmp_word(pin_oe, 32'h0);
    // Gate off freezes setup and change flags
    wr(8'h54, 32'h1);
    rd(8'h58, 32'h0, ALL);
    wr(8'h10, ALL);
    rd(8'h70, 32'h0, 32'h0);
    ext_e = ~ext_e;
    ext_level <= ext_e;
    tick(8);
    rd(8'h18, 32'h0, ALL);
    rd(8'h70, 32'h0, ALL);
    tick(2);
    $display("reset and gate test done");
    final_report();
  end
endmodule

bind uio_ctrl uio_ctrl_asserts chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .core_clock_src(core_clock_src),
  .bus_wait_input_n(bus_wait_input_n), .uio_irq(uio_irq));
